// ==== hdl/asmi_regs.sv ====
// Auxiliary SMI register bank: SMI gating, disk-change force bit and write-only shadows.
// Assumes a classic Wishbone master on clk_i and interrupt sources synchronous to clk_i.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "asmi_defines.svh"
module asmi_regs #(
	parameter int ADR_W = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Interrupt sources
	input wire logic parallel_irq_i,
	input wire logic serial_two_irq_i,
	input wire logic serial_one_irq_i,
	input wire logic floppy_irq_i,
	input wire logic watchdog_i,
	input wire logic mouse_irq_i,
	input wire logic keyboard_irq_i,
	input wire logic kbc_port_line_i,
	// Infrared receive pins
	input wire logic serial_two_receive_pin_i,
	input wire logic alt_infrared_receive_pin_i,
	// Floppy drive interface
	input wire logic floppy_step_n_i,
	input wire logic drive_select_zero_n_i,
	input wire logic disk_changed_pin_n_i,
	// Write-only register captures
	input wire logic rate_wr_i,
	input wire asmi_pkg::asmi_byte_t rate_data_i,
	input wire logic fifo_wr_i,
	input wire asmi_pkg::asmi_byte_t fifo_data_i,
	// Outputs
	output logic system_mgmt_irq_n_o,
	output logic smi_serial_irq_o,
	output logic disk_changed_bit_o,
	output logic ir_alt_select_o,
	output logic dma3_select_o,
	output logic kbc_select_o
);
	import asmi_pkg::*;

	// Index decoding needs bits [9:2]; narrower buses cannot reach the bank
	if (ADR_W < 10 || ADR_W > 32) begin : g_adr_check
		$error("asmi_regs: ADR_W must be 10 to 32");
	end

	// True when the word address selects the given register index
	function automatic logic reg_hit(input logic [ADR_W-1:0] a, input logic [7:0] idx);
		reg_hit = (a[ADR_W-1:2] == (ADR_W-2)'(idx));
	endfunction

	asmi_bus_state_t state_r;
	asmi_bus_state_t state_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;
	logic take_w;
	logic wr_w;
	logic rd_st2_w;
	asmi_byte_t rd_w;

	asmi_byte_t en1_r;
	asmi_byte_t en1_nxt;
	asmi_byte_t en2_r;
	asmi_byte_t en2_nxt;
	asmi_byte_t iropt_r;
	asmi_byte_t iropt_nxt;
	asmi_byte_t pmx_r;
	asmi_byte_t pmx_nxt;
	logic force_r;
	logic force_nxt;
	logic force_set_w;
	logic force_clr_w;
	asmi_byte_t rate_r;
	asmi_byte_t rate_nxt;
	asmi_byte_t fifo_r;
	asmi_byte_t fifo_nxt;

	asmi_byte_t st1_r;
	asmi_byte_t st1_nxt;
	asmi_byte_t st2_r;
	asmi_byte_t st2_nxt;
	logic ir_edge_w;

	asmi_byte_t pend_w;
	logic smi_n_r;
	logic smi_n_nxt;
	logic serirq_r;
	logic serirq_nxt;
	logic disk_changed_bit_r;
	logic disk_changed_bit_nxt;

	// Bus slave: one request is taken from idle, answered one cycle later, then idle again
	always_comb begin
		take_w = cyc_i && stb_i && (state_r == ASMI_BUS_IDLE);
		wr_w = take_w && we_i && sel_i[0];
		rd_st2_w = take_w && !we_i && reg_hit(adr_i, `ASMI_IDX_ST2);
		case (state_r)
			ASMI_BUS_IDLE: state_nxt = take_w ? ASMI_BUS_RESP : ASMI_BUS_IDLE;
			ASMI_BUS_RESP: state_nxt = ASMI_BUS_IDLE;
			default: state_nxt = ASMI_BUS_IDLE;
		endcase
		ack_nxt = take_w;
	end

	// Read mux; unmapped and reserved addresses read as zero and are still acknowledged
	always_comb begin
		rd_w = 8'h00;
		if (reg_hit(adr_i, `ASMI_IDX_EN1)) begin
			rd_w = en1_r;
		end else if (reg_hit(adr_i, `ASMI_IDX_EN2)) begin
			rd_w = en2_r;
		end else if (reg_hit(adr_i, `ASMI_IDX_ST1)) begin
			rd_w = st1_r;
		end else if (reg_hit(adr_i, `ASMI_IDX_ST2)) begin
			rd_w = st2_r;
		end else if (reg_hit(adr_i, `ASMI_IDX_PMX)) begin
			rd_w = pmx_r;
		end else if (reg_hit(adr_i, `ASMI_IDX_FDC)) begin
			rd_w = {`ASMI_FDC_RSV_RD, force_r};
		end else if (reg_hit(adr_i, `ASMI_IDX_RATE)) begin
			rd_w = rate_r;
		end else if (reg_hit(adr_i, `ASMI_IDX_FIFO)) begin
			rd_w = fifo_r;
		end else if (reg_hit(adr_i, `ASMI_IDX_IROPT)) begin
			rd_w = iropt_r;
		end
		dat_nxt = (take_w && !we_i) ? {24'h000000, rd_w} : 32'h00000000;
	end

	// Software-written control; reserved bits are masked so they always read zero
	always_comb begin
		en1_nxt = en1_r;
		en2_nxt = en2_r;
		pmx_nxt = pmx_r;
		iropt_nxt = iropt_r;
		if (wr_w && reg_hit(adr_i, `ASMI_IDX_EN1)) begin
			en1_nxt = dat_i[7:0] & `ASMI_EN1_MASK;
		end
		if (wr_w && reg_hit(adr_i, `ASMI_IDX_EN2)) begin
			en2_nxt = dat_i[7:0] & `ASMI_EN2_MASK;
		end
		if (wr_w && reg_hit(adr_i, `ASMI_IDX_PMX)) begin
			pmx_nxt = dat_i[7:0] & `ASMI_PMX_MASK;
		end
		if (wr_w && reg_hit(adr_i, `ASMI_IDX_IROPT)) begin
			iropt_nxt = dat_i[7:0] & `ASMI_IROPT_MASK;
		end
	end

	// Force bit: set by a written 1, cleared by step with drive 0; the set wins a tie
	always_comb begin
		force_set_w = wr_w && reg_hit(adr_i, `ASMI_IDX_FDC) && dat_i[0];
		force_clr_w = !floppy_step_n_i && !drive_select_zero_n_i;
		force_nxt = force_set_w || (force_r && !force_clr_w);
	end

	// Shadows capture every write the floppy and UART cores see
	always_comb begin
		rate_nxt = rate_wr_i ? rate_data_i : rate_r;
		fifo_nxt = fifo_wr_i ? fifo_data_i : fifo_r;
	end

	// Pin selection and transition detection on the infrared receive path
	asmi_ir_edge u_ir_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.alt_sel_i(iropt_r[`ASMI_IROPT_LOC]),
		.serial_two_receive_pin_i(serial_two_receive_pin_i),
		.alt_infrared_receive_pin_i(alt_infrared_receive_pin_i),
		.ir_edge_o(ir_edge_w)
	);

	// Status: level bits follow their sources, so reading never clears them
	always_comb begin
		st1_nxt = 8'h00;
		st1_nxt[`ASMI_ST1_PAR] = parallel_irq_i;
		st1_nxt[`ASMI_ST1_SER2] = serial_two_irq_i;
		st1_nxt[`ASMI_ST1_SER1] = serial_one_irq_i;
		st1_nxt[`ASMI_ST1_FLOP] = floppy_irq_i;
		st1_nxt[`ASMI_ST1_WDOG] = watchdog_i;
		st2_nxt = 8'h00;
		st2_nxt[`ASMI_ST2_MOUSE] = mouse_irq_i;
		st2_nxt[`ASMI_ST2_KBD] = keyboard_irq_i;
		// A new edge in the read cycle survives the read-clear
		st2_nxt[`ASMI_ST2_IR] = ir_edge_w || (st2_r[`ASMI_ST2_IR] && !rd_st2_w);
		st2_nxt[`ASMI_ST2_KBC] = kbc_port_line_i;
	end

	// Output terms; every output is a flop, so SMI lags a source by two cycles
	always_comb begin
		pend_w = (st1_r & en1_r) | (st2_r & en2_r);
		smi_n_nxt = ~(|pend_w);
		serirq_nxt = (|pend_w) && en2_r[`ASMI_EN2_SERIRQ];
		disk_changed_bit_nxt = (drive_select_zero_n_i && force_r) || disk_changed_pin_n_i;
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ASMI_BUS_IDLE;
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
			en1_r <= `ASMI_EN_RST;
			en2_r <= `ASMI_EN_RST;
			pmx_r <= `ASMI_PMX_RST;
			iropt_r <= `ASMI_IROPT_RST;
			force_r <= 1'b1;
			rate_r <= `ASMI_SHADOW_RST;
			fifo_r <= `ASMI_SHADOW_RST;
			st1_r <= 8'h00;
			st2_r <= 8'h00;
			smi_n_r <= 1'b1;
			serirq_r <= 1'b0;
			disk_changed_bit_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			en1_r <= en1_nxt;
			en2_r <= en2_nxt;
			pmx_r <= pmx_nxt;
			iropt_r <= iropt_nxt;
			force_r <= force_nxt;
			rate_r <= rate_nxt;
			fifo_r <= fifo_nxt;
			st1_r <= st1_nxt;
			st2_r <= st2_nxt;
			smi_n_r <= smi_n_nxt;
			serirq_r <= serirq_nxt;
			disk_changed_bit_r <= disk_changed_bit_nxt;
		end
	end

	// Ports straight from flops
	assign ack_o = ack_r;
	assign dat_o = dat_r;
	assign system_mgmt_irq_n_o = smi_n_r;
	assign smi_serial_irq_o = serirq_r;
	assign disk_changed_bit_o = disk_changed_bit_r;
	assign ir_alt_select_o = iropt_r[`ASMI_IROPT_LOC];
	assign dma3_select_o = pmx_r[`ASMI_PMX_DMA3];
	assign kbc_select_o = pmx_r[`ASMI_PMX_KBC];

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// SMI gating; checks that span the reset release skip the cycle the flops still hold reset
	smi_gate_a: assert property (pend_w != 8'h00 |=> !system_mgmt_irq_n_o)
		else $error("enabled pending source did not assert SMI");
	kbc_route_a: assert property (
		st2_r[`ASMI_ST2_KBC] && !en2_r[`ASMI_ST2_KBC] && (pend_w == 8'h00)
		|=> system_mgmt_irq_n_o)
		else $error("unrouted port line reached SMI");
	kbc_enable_a: assert property (
		st2_r[`ASMI_ST2_KBC] && en2_r[`ASMI_ST2_KBC] |=> !system_mgmt_irq_n_o)
		else $error("routed port line missing from SMI");
	serirq_gate_a: assert property (!en2_r[`ASMI_EN2_SERIRQ] |=> !smi_serial_irq_o)
		else $error("serial IRQ asserted while disabled");
	serirq_on_a: assert property (
		pend_w != 8'h00 && en2_r[`ASMI_EN2_SERIRQ] |=> smi_serial_irq_o)
		else $error("enabled SMI missing from serial IRQ");

	// Status layout and clearing
	st1_map_a: assert property (
		!rst_i |=> st1_r == {$past(watchdog_i), 2'b00, $past(floppy_irq_i),
			$past(serial_one_irq_i), $past(serial_two_irq_i),
			$past(parallel_irq_i), 1'b0})
		else $error("status one field layout wrong");
	st1_noclr_a: assert property (
		take_w && reg_hit(adr_i, `ASMI_IDX_ST1) && serial_one_irq_i
		|=> st1_r[`ASMI_ST1_SER1] ##1 (st1_r[`ASMI_ST1_SER1] || !$past(serial_one_irq_i)))
		else $error("status one cleared by access");
	st2_mirror_a: assert property (
		!rst_i |=> st2_r[`ASMI_ST2_MOUSE] == $past(mouse_irq_i)
		&& st2_r[`ASMI_ST2_KBD] == $past(keyboard_irq_i))
		else $error("mouse or keyboard mirror wrong");
	ir_set_a: assert property (ir_edge_w |=> st2_r[`ASMI_ST2_IR])
		else $error("infrared edge lost");
	ir_clr_a: assert property (rd_st2_w && !ir_edge_w |=> !st2_r[`ASMI_ST2_IR])
		else $error("infrared flag not cleared by read");
	kbc_mirror_a: assert property (
		!rst_i |=> st2_r[`ASMI_ST2_KBC] == $past(kbc_port_line_i))
		else $error("port line status wrong");

	// Force bit and disk change
	force_hold_a: assert property (force_r && floppy_step_n_i |=> force_r)
		else $error("force bit cleared without step");
	force_set_a: assert property (force_set_w |=> force_r)
		else $error("force bit not set by write");
	force_clr_a: assert property (force_clr_w && !force_set_w |=> !force_r)
		else $error("force bit not cleared by step");
	disk_changed_bit_eq_a: assert property (
		!rst_i |=> disk_changed_bit_o == (($past(drive_select_zero_n_i) && $past(force_r))
		|| $past(disk_changed_pin_n_i)))
		else $error("disk change bit wrong");

	// Shadows
	rate_shadow_a: assert property (
		rate_wr_i |=> rate_r == $past(rate_data_i) [*2] or rate_wr_i)
		else $error("rate shadow lost write");
	fifo_shadow_a: assert property (
		fifo_wr_i ##1 !fifo_wr_i |-> fifo_r == $past(fifo_data_i))
		else $error("FIFO shadow lost write");

	// SMI release and bus answer shape
	smi_release_a: assert property (
		pend_w == 8'h00 ##1 pend_w == 8'h00 |-> system_mgmt_irq_n_o)
		else $error("SMI held without pending source");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held two cycles");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h00000000)
		else $error("read data shown outside ack");

	// Main scenarios
	smi_seen_c: cover property (!system_mgmt_irq_n_o ##[1:20] system_mgmt_irq_n_o);
	kbc_route_c: cover property (st2_r[`ASMI_ST2_KBC] && en2_r[`ASMI_ST2_KBC]);
	ir_read_c: cover property (st2_r[`ASMI_ST2_IR] ##1 rd_st2_w ##2 !st2_r[`ASMI_ST2_IR]);
	force_cycle_c: cover property (force_set_w ##[1:20] force_clr_w);
	serirq_c: cover property (smi_serial_irq_o);

endmodule // asmi_regs

// ==== hdl/asmi_defines.svh ====
// Register indexes, field positions, masks and reset values of the auxiliary SMI bank.
// Assumes a Wishbone slave that places register index N at byte address 4*N.
`ifndef ASMI_DEFINES_SVH
`define ASMI_DEFINES_SVH

// Register indexes (byte address is four times the index)
`define ASMI_IDX_EN1 8'hb4
`define ASMI_IDX_EN2 8'hb5
`define ASMI_IDX_ST1 8'hb6
`define ASMI_IDX_ST2 8'hb7
`define ASMI_IDX_RSV 8'hb8
`define ASMI_IDX_PMX 8'hc0
`define ASMI_IDX_FDC 8'hc1
`define ASMI_IDX_RATE 8'hc2
`define ASMI_IDX_FIFO 8'hc3
`define ASMI_IDX_IROPT 8'hf1

// Writable bit masks
`define ASMI_EN1_MASK 8'h9e
`define ASMI_EN2_MASK 8'h57
`define ASMI_PMX_MASK 8'h0a
`define ASMI_IROPT_MASK 8'h7f

// Reset values, and the fixed read value of the FDC reserved bits
`define ASMI_EN_RST 8'h00
`define ASMI_PMX_RST 8'h02
`define ASMI_IROPT_RST 8'h02
`define ASMI_SHADOW_RST 8'h00
`define ASMI_FDC_RSV_RD 7'h01

// Field positions
`define ASMI_ST1_PAR 1
`define ASMI_ST1_SER2 2
`define ASMI_ST1_SER1 3
`define ASMI_ST1_FLOP 4
`define ASMI_ST1_WDOG 7
`define ASMI_ST2_MOUSE 0
`define ASMI_ST2_KBD 1
`define ASMI_ST2_IR 2
`define ASMI_ST2_KBC 4
`define ASMI_EN2_SERIRQ 6
`define ASMI_IROPT_LOC 6
`define ASMI_PMX_DMA3 1
`define ASMI_PMX_KBC 3

`endif

// ==== hdl/asmi_pkg.sv ====
// Types shared by the auxiliary SMI register bank.
// Constants live in asmi_defines.svh; this package holds only types.
package asmi_pkg;

	typedef logic [7:0] asmi_byte_t;

	// Wishbone slave states, one-hot
	typedef enum logic [1:0] {
		ASMI_BUS_IDLE = 2'b01,
		ASMI_BUS_RESP = 2'b10
	} asmi_bus_state_t;

endpackage

// ==== hdl/asmi_ir_edge.sv ====
// Infrared receive pin selector and transition detector.
// Assumes both pins are already synchronous to clk_i.
`timescale 1ns/1ps
module asmi_ir_edge (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic alt_sel_i,
	input wire logic serial_two_receive_pin_i,
	input wire logic alt_infrared_receive_pin_i,
	output logic ir_edge_o
);
	import asmi_pkg::*;

	logic ir_mux_w;
	logic prev_r;
	logic prev_nxt;

	// Pin selection sits before the detector so a mux change can itself flag an edge
	always_comb begin
		ir_mux_w = alt_sel_i ? alt_infrared_receive_pin_i : serial_two_receive_pin_i;
		prev_nxt = ir_mux_w;
		ir_edge_o = ir_mux_w ^ prev_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Track the pin through reset: a pin idling high must not look like an edge
			prev_r <= prev_nxt;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ir_mux_sel_a: assert property (alt_sel_i |=> prev_r == $past(alt_infrared_receive_pin_i))
		else $error("alternate infrared pin not selected");
	ir_mux_ser_a: assert property (!alt_sel_i |=> prev_r == $past(serial_two_receive_pin_i))
		else $error("serial receive pin not selected");

endmodule // asmi_ir_edge

// ==== dv/test_aux_smi_register_bank.sv ====
// Self-checking bench for the auxiliary SMI register bank, driven over classic Wishbone.
// Assumes asmi_regs answers one cycle after taking a request and all inputs sit on clk_i.
`timescale 1ns/1ps
`include "asmi_defines.svh"
module test_aux_smi_register_bank;
	import asmi_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [11:0] adr_i = 12'h000;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o, smi_n, serirq, disk_changed_bit, ir_alt, dma3, kbc;
	logic [7:0] src1 = 8'h00, src2 = 8'h00;
	logic rx2 = 1'b0, alt_infrared_receive_pin = 1'b0, step_n = 1'b1, ds0_n = 1'b1, dsk_n = 1'b1;
	logic rate_wr = 1'b0, fifo_wr = 1'b0;
	asmi_byte_t rate_d = 8'h00, fifo_d = 8'h00;
	int errors = 0, num_checks = 0, cycles = 0;

	// Source vectors keep status bit positions so expectations are plain shifts
	asmi_regs #(.ADR_W(12)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.parallel_irq_i(src1[1]), .serial_two_irq_i(src1[2]), .serial_one_irq_i(src1[3]),
		.floppy_irq_i(src1[4]), .watchdog_i(src1[7]), .mouse_irq_i(src2[0]),
		.keyboard_irq_i(src2[1]), .kbc_port_line_i(src2[4]), .serial_two_receive_pin_i(rx2),
		.alt_infrared_receive_pin_i(alt_infrared_receive_pin), .floppy_step_n_i(step_n),
		.drive_select_zero_n_i(ds0_n), .disk_changed_pin_n_i(dsk_n), .rate_wr_i(rate_wr),
		.rate_data_i(rate_d), .fifo_wr_i(fifo_wr), .fifo_data_i(fifo_d),
		.system_mgmt_irq_n_o(smi_n), .smi_serial_irq_o(serirq), .disk_changed_bit_o(disk_changed_bit),
		.ir_alt_select_o(ir_alt), .dma3_select_o(dma3), .kbc_select_o(kbc));

	// 250 MHz clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	// Hang guard: far above the several hundred cycles the scenarios need
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			$display("unexpected at %0t: run timed out", $time);
			test_done;
		end
	end

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("unexpected at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("unexpected at %0t: pin %b expected %b", $time, got, exp);
		end
	endtask

	// One classic cycle; ack and data are read right after each rising edge, before the
	// design's flops update, so they are the values sampled at that edge
	task automatic wb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= wr;
		sel_i <= 4'h1;
		adr_i <= {2'b00, idx, 2'b00};
		dat_i <= {24'h0, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors = errors + 1;
			$display("unexpected at %0t: no bus answer", $time);
		end
		// Release on the same edge that saw ack high
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		wb(idx, 1'b1, d, x);
	endtask

	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		wb(idx, 1'b0, 8'h00, x);
		chk_byte(x, exp);
	endtask

	// Lets registered outputs land before looking at them
	task automatic settle;
		repeat (4) @(posedge clk_i);
		#1;
	endtask

	task automatic test_reset;
		settle;
		chk_bit(smi_n, 1'b1);
		chk_bit(serirq, 1'b0);
		chk_bit(dma3, 1'b1);
		chk_bit(kbc, 1'b0);
		chk_bit(ir_alt, 1'b0);
		chk_bit(disk_changed_bit, 1'b1);
		rc(`ASMI_IDX_RATE, `ASMI_SHADOW_RST);
		rc(`ASMI_IDX_FIFO, `ASMI_SHADOW_RST);
		rc(`ASMI_IDX_EN1, 8'h00);
		rc(`ASMI_IDX_EN2, 8'h00);
		rc(`ASMI_IDX_ST1, 8'h00);
		rc(`ASMI_IDX_ST2, 8'h00);
		rc(`ASMI_IDX_RSV, 8'h00);
		rc(`ASMI_IDX_PMX, 8'h02);
		rc(`ASMI_IDX_FDC, 8'h03);
		rc(`ASMI_IDX_IROPT, 8'h02);
		rc(8'h10, 8'h00);
	endtask

	task automatic test_access;
		wr(`ASMI_IDX_EN1, 8'hff);
		rc(`ASMI_IDX_EN1, 8'h9e);
		wr(`ASMI_IDX_EN2, 8'hff);
		rc(`ASMI_IDX_EN2, 8'h57);
		wr(`ASMI_IDX_ST1, 8'hff);
		rc(`ASMI_IDX_ST1, 8'h00);
		wr(`ASMI_IDX_RSV, 8'hff);
		rc(`ASMI_IDX_RSV, 8'h00);
		wr(8'h10, 8'hff);
		rc(8'h10, 8'h00);
		wr(`ASMI_IDX_PMX, 8'hff);
		rc(`ASMI_IDX_PMX, 8'h0a);
		settle;
		chk_bit(kbc, 1'b1);
		wr(`ASMI_IDX_PMX, 8'h00);
		settle;
		chk_bit(dma3, 1'b0);
		wr(`ASMI_IDX_PMX, 8'h02);
		wr(`ASMI_IDX_EN1, 8'h00);
		wr(`ASMI_IDX_EN2, 8'h00);
	endtask

	// Raise one source, check status and gating by its own and by all other enables
	task automatic gate_case(input logic two, input int b);
		logic [7:0] en = two ? `ASMI_IDX_EN2 : `ASMI_IDX_EN1;
		logic [7:0] st = two ? `ASMI_IDX_ST2 : `ASMI_IDX_ST1;
		logic [7:0] all = two ? 8'h57 : 8'h9e;
		logic [7:0] m = 8'h01 << b;
		@(posedge clk_i);
		if (two)
			src2 <= m;
		else
			src1 <= m;
		settle;
		chk_bit(smi_n, 1'b1);
		rc(st, m);
		rc(st, m);
		wr(en, all & ~m);
		settle;
		chk_bit(smi_n, 1'b1);
		wr(en, m);
		settle;
		chk_bit(smi_n, 1'b0);
		@(posedge clk_i);
		src1 <= 8'h00;
		src2 <= 8'h00;
		settle;
		chk_bit(smi_n, 1'b1);
		rc(st, 8'h00);
		wr(en, 8'h00);
	endtask

	task automatic test_gating;
		int b1[5] = '{1, 2, 3, 4, 7};
		int b2[3] = '{0, 1, 4};
		foreach (b1[i]) gate_case(1'b0, b1[i]);
		foreach (b2[i]) gate_case(1'b1, b2[i]);
		wr(`ASMI_IDX_EN1, 8'h10);
		wr(`ASMI_IDX_EN2, 8'h40);
		@(posedge clk_i);
		src1 <= 8'h10;
		settle;
		chk_bit(serirq, 1'b1);
		wr(`ASMI_IDX_EN2, 8'h00);
		settle;
		chk_bit(serirq, 1'b0);
		chk_bit(smi_n, 1'b0);
		@(posedge clk_i);
		src1 <= 8'h00;
		wr(`ASMI_IDX_EN1, 8'h00);
	endtask

	task automatic test_ir;
		@(posedge clk_i);
		rx2 <= 1'b1;
		settle;
		rc(`ASMI_IDX_ST2, 8'h04);
		rc(`ASMI_IDX_ST2, 8'h00);
		@(posedge clk_i);
		alt_infrared_receive_pin <= 1'b1;
		settle;
		rc(`ASMI_IDX_ST2, 8'h00);
		wr(`ASMI_IDX_IROPT, 8'h42);
		settle;
		chk_bit(ir_alt, 1'b1);
		@(posedge clk_i);
		rx2 <= 1'b0;
		settle;
		rc(`ASMI_IDX_ST2, 8'h00);
		@(posedge clk_i);
		alt_infrared_receive_pin <= 1'b0;
		settle;
		rc(`ASMI_IDX_ST2, 8'h04);
		rc(`ASMI_IDX_ST2, 8'h00);
		wr(`ASMI_IDX_IROPT, 8'h02);
	endtask

	task automatic test_disk;
		@(posedge clk_i);
		dsk_n <= 1'b0;
		step_n <= 1'b0;
		settle;
		chk_bit(disk_changed_bit, 1'b1);
		rc(`ASMI_IDX_FDC, 8'h03);
		@(posedge clk_i);
		ds0_n <= 1'b0;
		@(posedge clk_i);
		ds0_n <= 1'b1;
		step_n <= 1'b1;
		settle;
		chk_bit(disk_changed_bit, 1'b0);
		wr(`ASMI_IDX_FDC, 8'h00);
		rc(`ASMI_IDX_FDC, 8'h02);
		wr(`ASMI_IDX_FDC, 8'h01);
		rc(`ASMI_IDX_FDC, 8'h03);
		settle;
		chk_bit(disk_changed_bit, 1'b1);
		wr(`ASMI_IDX_FDC, 8'h00);
		rc(`ASMI_IDX_FDC, 8'h03);
		@(posedge clk_i);
		dsk_n <= 1'b1;
		ds0_n <= 1'b0;
		settle;
		chk_bit(disk_changed_bit, 1'b1);
	endtask

	task automatic test_shadow;
		@(posedge clk_i);
		rate_d <= 8'ha5;
		rate_wr <= 1'b1;
		@(posedge clk_i);
		rate_d <= 8'hc3;
		@(posedge clk_i);
		rate_wr <= 1'b0;
		fifo_d <= 8'hcf;
		fifo_wr <= 1'b1;
		@(posedge clk_i);
		fifo_wr <= 1'b0;
		rc(`ASMI_IDX_RATE, 8'hc3);
		rc(`ASMI_IDX_FIFO, 8'hcf);
		wr(`ASMI_IDX_RATE, 8'h11);
		rc(`ASMI_IDX_RATE, 8'hc3);
	endtask

	// Main sequence: reset held 16 cycles, then every scenario in turn
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset;
		test_access;
		test_gating;
		test_ir;
		test_disk;
		test_shadow;
		test_done;
	end
endmodule // test_aux_smi_register_bank
